// ==== common/ptc_pkg.sv ====
/*
 Package for the prescaled timer/counter: register offsets, field
 positions, reset values and cycle counts.
 Assumes a single 100 MHz clock and an APB slave with 32-bit data.
*/
package ptc_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] PTC_OFF_CONTROL = 8'h00;
   localparam logic [7:0] PTC_OFF_COUNT_LOW = 8'h04;
   localparam logic [7:0] PTC_OFF_HIGH_BUF = 8'h08;
   localparam logic [7:0] PTC_OFF_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] PTC_OFF_IRQ_MASK = 8'h10;
   // ==========================================================
   // Control register fields
   localparam int PTC_BIT_RUN = 7;
   localparam int PTC_BIT_NARROW = 6;
   localparam int PTC_BIT_SOURCE = 5;
   localparam int PTC_BIT_EDGE = 4;
   localparam int PTC_BIT_BYPASS = 3;
   localparam int PTC_RATIO_MSB = 2;
   localparam int PTC_RATIO_LSB = 0;
   // ==========================================================
   // Reset values
   localparam logic [7:0] PTC_CONTROL_RESET = 8'hFF;
   localparam logic [7:0] PTC_HIGH_BUF_RESET = 8'h00;
   localparam logic [15:0] PTC_COUNT_RESET = 16'h0000;
   localparam logic [7:0] PTC_MASK_RESET = 8'h00;
   // ==========================================================
   // Timing: instruction cycle is four clock periods
   localparam int PTC_CLK_PERIOD_NS = 10;
   localparam int PTC_INSTR_PERIOD_NS = 40;
   localparam int PTC_INSTR_CYCLES = PTC_INSTR_PERIOD_NS / PTC_CLK_PERIOD_NS;
   localparam int PTC_WRITE_INHIBIT_INSTR = 2;
   localparam logic [1:0] PTC_INSTR_LAST = 2'(PTC_INSTR_CYCLES - 1);
   localparam logic [1:0] PTC_INHIBIT_LOAD = 2'(PTC_WRITE_INHIBIT_INSTR);
endpackage : ptc_pkg

// ==== src/ptc_timer.sv ====
/*
 Prescaled 8/16-bit timer/counter with an APB register slave.
 Assumes the external count pin is asynchronous to clk_in and that
 the APB master follows the standard setup/access sequence.
*/
`timescale 1ns/1ps

module ptc_timer (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic external_count_pin_in,
   output logic irq_out
);
   // ==========================================================
   // APB decode
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   wire setup_phase = psel_in && !penable_in;
   // Writes land at the edge that ends the access phase, as the master sees pready
   wire access_phase = psel_in && penable_in && pready_q;
   wire wr_access = access_phase && pwrite_in && pstrb_in[0];
   wire rd_setup = setup_phase && !pwrite_in;
   wire hit_control = paddr_in == ptc_pkg::PTC_OFF_CONTROL;
   wire hit_low = paddr_in == ptc_pkg::PTC_OFF_COUNT_LOW;
   wire hit_high = paddr_in == ptc_pkg::PTC_OFF_HIGH_BUF;
   wire hit_status = paddr_in == ptc_pkg::PTC_OFF_IRQ_STATUS;
   wire hit_mask = paddr_in == ptc_pkg::PTC_OFF_IRQ_MASK;
   wire hit_any = hit_control | hit_low | hit_high | hit_status | hit_mask;
   wire wr_control = wr_access && hit_control;
   wire wr_low = wr_access && hit_low;
   wire wr_high = wr_access && hit_high;
   wire wr_status = wr_access && hit_status;
   wire wr_mask = wr_access && hit_mask;
   wire rd_low = rd_setup && hit_low;
   wire [7:0] wbyte = pwdata_in[7:0];

   // ==========================================================
   // Registers
   logic [7:0] control_q;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [7:0] high_buf_q;
   logic overflow_flag_q;
   logic overflow_irq_enable_q;
   logic [7:0] prescale_q;
   logic [1:0] instr_div_q;
   logic [1:0] inhibit_q;
   logic pin_meta_q;
   logic pin_sync_q;
   logic pin_prev_q;

   wire run_enable = control_q[ptc_pkg::PTC_BIT_RUN];
   wire narrow_width_select = control_q[ptc_pkg::PTC_BIT_NARROW];
   wire count_source_select = control_q[ptc_pkg::PTC_BIT_SOURCE];
   wire source_edge_select = control_q[ptc_pkg::PTC_BIT_EDGE];
   wire prescaler_bypass = control_q[ptc_pkg::PTC_BIT_BYPASS];
   wire [2:0] prescale_ratio_select =
      control_q[ptc_pkg::PTC_RATIO_MSB:ptc_pkg::PTC_RATIO_LSB];

   // ==========================================================
   // Clock source selection
   wire instr_tick = instr_div_q == ptc_pkg::PTC_INSTR_LAST;
   wire pin_rise = pin_sync_q && !pin_prev_q;
   wire pin_fall = !pin_sync_q && pin_prev_q;
   wire pin_edge = source_edge_select ? pin_fall : pin_rise;
   wire source_tick = count_source_select ? pin_edge : instr_tick;

   // Prescaler output: ratio 2^(code+1), taken when the low code+1 prescaler bits are all ones
   wire [7:0] prescale_next = prescale_q + 8'h01;
   wire [7:0] ratio_mask = 8'((9'h002 << prescale_ratio_select) - 9'h001);
   wire prescale_tick = source_tick && ((prescale_q & ratio_mask) == ratio_mask);
   wire count_tick = prescaler_bypass ? source_tick : prescale_tick;
   wire inc_allowed = run_enable && (inhibit_q == 2'h0) && !wr_low;
   wire do_inc = inc_allowed && count_tick;
   wire overflow = do_inc && (narrow_width_select ? (count_q[7:0] == 8'hFF)
                                                  : (count_q == 16'hFFFF));

   always_comb begin
      count_d = count_q;
      if (wr_low) begin
         if (narrow_width_select) begin
            count_d = {count_q[15:8], wbyte};
         end else begin
            count_d = {high_buf_q, wbyte};
         end
      end else if (do_inc) begin
         if (narrow_width_select) begin
            count_d = {count_q[15:8], count_q[7:0] + 8'h01};
         end else begin
            count_d = count_q + 16'h0001;
         end
      end
   end

   // ==========================================================
   // Synchroniser for the count pin
   always_ff @(posedge clk_in) begin
      pin_meta_q <= external_count_pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
   end

   // ==========================================================
   // Counter, prescaler and inhibit
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         count_q <= ptc_pkg::PTC_COUNT_RESET;
         prescale_q <= 8'h00;
         instr_div_q <= 2'h0;
         inhibit_q <= 2'h0;
      end else begin
         count_q <= count_d;
         instr_div_q <= instr_div_q + 2'h1;
         if (wr_low) begin
            inhibit_q <= ptc_pkg::PTC_INHIBIT_LOAD;
         end else if (instr_tick && inhibit_q != 2'h0) begin
            inhibit_q <= inhibit_q - 2'h1;
         end
         if (wr_low && !prescaler_bypass) begin
            prescale_q <= 8'h00;
         end else if (run_enable && source_tick && !prescaler_bypass) begin
            prescale_q <= prescale_next;
         end
      end
   end

   // ==========================================================
   // Software registers
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         control_q <= ptc_pkg::PTC_CONTROL_RESET;
         high_buf_q <= ptc_pkg::PTC_HIGH_BUF_RESET;
         overflow_flag_q <= 1'b0;
         overflow_irq_enable_q <= 1'b0;
      end else begin
         if (wr_control) begin
            control_q <= wbyte;
         end
         if (wr_high) begin
            high_buf_q <= wbyte;
         end else if (rd_low && !narrow_width_select) begin
            high_buf_q <= count_q[15:8];
         end
         if (overflow) begin
            overflow_flag_q <= 1'b1;
         end else if (wr_status && wbyte[0]) begin
            overflow_flag_q <= 1'b0;
         end
         if (wr_mask) begin
            overflow_irq_enable_q <= wbyte[0];
         end
      end
   end

   // ==========================================================
   // APB answer and interrupt
   wire [7:0] rd_byte =
      hit_control ? control_q :
      hit_low ? count_q[7:0] :
      hit_high ? high_buf_q :
      hit_status ? {7'h00, overflow_flag_q} :
      hit_mask ? {7'h00, overflow_irq_enable_q} : 8'h00;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         pready_q <= setup_phase;
         pslverr_q <= setup_phase && !hit_any;
         if (rd_setup) begin
            prdata_q <= {24'h000000, rd_byte};
         end
         irq_q <= overflow_flag_q && overflow_irq_enable_q;
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign irq_out = irq_q;
endmodule : ptc_timer

// ==== verification/ptc_pin_src.sv ====
/* External count source for the timer's count pin.
   Assumes one bench clock; the pin holds its level while run_in is low. */
`timescale 1ns/1ps
module ptc_pin_src (
   input wire logic clk_in,
   input wire logic run_in,
   output logic pin_out
);
   logic [2:0] div_q = 3'h0;
   initial pin_out = 1'b0;
   always @(posedge clk_in) begin
      div_q <= div_q + 3'h1;
      if (run_in && div_q == 3'h7) pin_out <= ~pin_out;
   end
endmodule : ptc_pin_src

// ==== verification/ptc_timer_monitor.sv ====
/* Port checker for the timer's APB slave and interrupt output.
   Assumes it is bound to every ptc_timer instance. */
`timescale 1ns/1ps
module ptc_monitor (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic irq_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire setup = psel_in && !penable_in;
   wire bad = paddr_in > 8'h10 || paddr_in[1:0] != 2'h0;
   wire irqw = setup && pwrite_in && (paddr_in == 8'h0C || paddr_in == 8'h10);
   logic irqw_q;
   logic irqw_qq;
   always_ff @(posedge clk_in) irqw_q <= irqw;
   always_ff @(posedge clk_in) irqw_qq <= irqw_q;
   property p_rdy; setup |=> pready_out; endproperty
   a_rdy: assert property (p_rdy) else $error("no pready after setup");
   property p_one; pready_out |=> !pready_out; endproperty
   a_one: assert property (p_one) else $error("pready longer than one cycle");
   property p_unm; setup && bad |=> pslverr_out; endproperty
   a_unm: assert property (p_unm) else $error("unmapped access not refused");
   property p_ok; setup && !bad |=> !pslverr_out; endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_err; pslverr_out |-> pready_out && psel_in && penable_in; endproperty
   a_err: assert property (p_err) else $error("pslverr outside access phase");
   property p_hi; prdata_out[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("read data upper bits set");
   property p_rst; $rose(rst_b_in) |-> !irq_out && !pready_out && prdata_out == 32'h0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_irq; irq_out && !irqw && !irqw_q && !irqw_qq |=> irq_out; endproperty
   a_irq: assert property (p_irq) else $error("interrupt dropped without clear");
   property p_prd; !$stable(prdata_out) |-> $past(setup && !pwrite_in); endproperty
   a_prd: assert property (p_prd) else $error("read data changed without read");
   c_irq: cover property ($rose(irq_out));
   c_err: cover property (pslverr_out);
   c_rd: cover property (setup && !pwrite_in && paddr_in == 8'h04);
endmodule : ptc_monitor
bind ptc_timer ptc_monitor u_mon (.*);

// ==== verification/ptc_timer_tb.sv ====
/* Bench for ptc_timer: APB master, count model and pin source.
   Assumes ptc_pkg, the design and the pin source are compiled first. */
`timescale 1ns/1ps
module ptc_timer_tb;
   logic clk_in = 1'b0, rst_b_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic src_run = 1'b0, rdy, err, perr, irq, pin;
   logic [7:0] padr = 8'h00, v, d;
   logic [31:0] pwd = 32'h0, rdat, prd;
   int error_cnt = 0, n_tests = 0, cyc = 0, cnt, per;
   always #5 clk_in = ~clk_in;
   ptc_timer dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .pstrb_in(4'hF), .prdata_out(prd),
      .pready_out(rdy), .pslverr_out(perr), .external_count_pin_in(pin), .irq_out(irq));
   ptc_pin_src src (.clk_in(clk_in), .run_in(src_run), .pin_out(pin));
   // ==========================================================
   // Tasks
   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= dat;
      @(posedge clk_in);
      pen <= 1'b1;
      do @(posedge clk_in); while (rdy !== 1'b1);
      rdat = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic rd_diff(input logic [7:0] ctl, input int gap);
      logic [7:0] t0;
      apb(1'b1, 8'h00, {24'h0, ctl});
      apb(1'b0, 8'h04, 32'h0);
      t0 = rdat[7:0];
      repeat (gap - 3) @(posedge clk_in);
      apb(1'b0, 8'h04, 32'h0);
      chk({24'h0, rdat[7:0] - t0}, 32'h2);
   endtask : rd_diff
   task automatic edge1(input logic e);
      logic p0;
      p0 = pin;
      src_run <= 1'b1;
      do @(posedge clk_in); while (pin === p0);
      src_run <= 1'b0;
      repeat (8) @(posedge clk_in);
      apb(1'b0, 8'h04, 32'h0);
      if (pin ^ e) cnt++;
      chk(rdat, 32'(cnt & 255));
   endtask : edge1
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(78));
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rdat, i == 0 ? 32'hFF : 32'h0);
      end
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      v = 8'($urandom);
      apb(1'b1, 8'h00, {24'h0, v & 8'h7F});
      apb(1'b0, 8'h00, 32'h0);
      chk(rdat, {24'h0, v & 8'h7F});
      apb(1'b1, 8'h04, {24'h0, v});
      repeat (40) @(posedge clk_in);
      apb(1'b0, 8'h04, 32'h0);
      chk(rdat, {24'h0, v});
      apb(1'b1, 8'h00, 32'hC8);
      apb(1'b1, 8'h04, {24'h0, v});
      repeat (17) @(posedge clk_in);
      apb(1'b0, 8'h04, 32'h0);
      d = rdat[7:0] - v;
      chk({31'h0, d == 8'h2 || d == 8'h3}, 32'h1);
      for (int c = 0; c <= 8; c++) begin
         per = (c == 8) ? 1 : (2 << c);
         rd_diff(c == 8 ? 8'hC8 : 8'(8'hC0 + c), 8 * per);
      end
      apb(1'b1, 8'h10, 32'h1);
      apb(1'b1, 8'h04, 32'hFE);
      repeat (40) @(posedge clk_in);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 8'h0C, 32'h1);
      apb(1'b0, 8'h0C, 32'h0);
      chk({30'h0, irq, rdat[0]}, 32'h0);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h04, 32'hFE);
      repeat (40) @(posedge clk_in);
      apb(1'b0, 8'h0C, 32'h0);
      chk({30'h0, irq, rdat[0]}, 32'h1);
      apb(1'b1, 8'h00, 32'h08);
      apb(1'b1, 8'h08, 32'hFF);
      apb(1'b1, 8'h04, 32'hFF);
      apb(1'b1, 8'h0C, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(rdat, 32'hFF);
      apb(1'b1, 8'h00, 32'h88);
      repeat (40) @(posedge clk_in);
      apb(1'b0, 8'h04, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rdat, 32'h1);
      apb(1'b1, 8'h00, 32'hC7);
      repeat (3) begin
         apb(1'b1, 8'h04, 32'h0);
         repeat (600) @(posedge clk_in);
      end
      apb(1'b0, 8'h04, 32'h0);
      chk(rdat, 32'h0);
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, 8'h00, 32'(8'hA8 + 16 * e));
         apb(1'b1, 8'h04, 32'h0);
         repeat (10) @(posedge clk_in);
         cnt = 0;
         edge1(1'(e));
         edge1(1'(e));
      end
      results();
   end
endmodule : ptc_timer_tb
